/* File: rtl/dbc_cache.sv */
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module dbc_cache
    import dbc_pkg::*;
#(
    parameter int NSEG = 64,
    parameter int SEG_SECT = 16,
    parameter int CYL_SECT = 1024,
    parameter int SEEK_TRIES = 4
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Medium channel
    output dbc_med_req_t med_req,
    input wire dbc_med_rsp_t med_rsp
);
    localparam int SW = $clog2(NSEG);
    localparam int PW = $clog2(SEG_SECT);
    localparam int LW = PW + 1;
    localparam int RW = $clog2(SEEK_TRIES + 1);
    localparam logic [SW:0] NSEG_RST = (SW + 1)'(NSEG);
    localparam logic [SW:0] NSEG_ONE = (SW + 1)'(1);
    localparam logic [LW-1:0] LEN_FULL = LW'(SEG_SECT);
    localparam logic [7:0] CNT_FULL = 8'(SEG_SECT);
    localparam logic [RW-1:0] TRY_MAX = RW'(SEEK_TRIES);

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_WDRAIN = 3'h1,
        S_WFILL = 3'h2,
        S_WWAIT = 3'h3,
        S_SYNC = 3'h4,
        S_RLOOK = 3'h5,
        S_RMED = 3'h6,
        S_PREF = 3'h7
    } dbc_state_t;

    typedef struct packed {
        dbc_state_t st;
        logic [31:0] page;
        logic [31:0] cmd_lba;
        logic [7:0] cmd_cnt;
        dbc_op_t op;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        dbc_med_req_t med;
        logic [NSEG-1:0][31:0] base;
        logic [NSEG-1:0][LW-1:0] len;
        logic [NSEG-1:0] v;
        logic [NSEG-1:0] pf;
        logic [SW-1:0] rr;
        logic [SW-1:0] seg;
        logic [SW:0] nseg;
        logic [SEG_SECT-1:0] dirty;
        logic [PW-1:0] wp;
        logic [PW-1:0] cp;
        logic [31:0] c_lba;
        logic [31:0] r_lba;
        logic [7:0] left;
        logic [15:0] pf_left;
        logic [RW-1:0] retry;
        logic busy;
        logic good;
        logic check;
        logic deferred;
        logic hit;
        logic pf_hit;
        logic pf_on;
        logic wgood;
        logic [3:0] sk;
        logic [7:0] asc;
        logic [7:0] err_cnt;
        logic [31:0] err_lba;
        logic err_seen;
        logic [31:0] last_end;
    } dbc_st_t;

    dbc_st_t r;
    dbc_st_t n;
    logic [NSEG-1:0] hit_v;
    logic [NSEG-1:0] ovl_v;
    logic [SW-1:0] hi;
    logic [SW-1:0] vic;
    logic [SW:0] fixed_n;
    logic [7:0] segn;
    logic [15:0] maxpf;
    logic [LW-1:0] room;
    logic [31:0] stat;
    logic [31:0] gap;
    logic contig;
    logic ack;
    logic fail;
    logic rd_ok;
    logic rd_fail;
    logic wr_acc;
    logic pf_go;
    logic pf_more;

    function automatic logic [PW-1:0] nxt_p(input logic [PW-1:0] p);
        return (p == PW'(SEG_SECT - 1)) ? '0 : p + 1'b1;
    endfunction : nxt_p

    function automatic logic [SW-1:0] nxt_rr(input logic [SW-1:0] x, input logic [SW:0] cnt);
        return ({1'b0, x} + NSEG_ONE >= cnt) ? '0 : x + 1'b1;
    endfunction : nxt_rr

    // Address table per segment for hit and overlap detection
    for (genvar i = 0; i < NSEG; i++)
    begin : g_seg
        localparam logic [SW:0] IDX = (SW + 1)'(i);
        logic [31:0] off;
        assign off = r.cmd_lba - r.base[i];
        // Pass-through segments must not count as hits when rcd is set
        assign hit_v[i] = r.v[i] && (IDX < r.nseg) && (off < 32'(r.len[i]))
            && (!r.page[B_RCD] || r.pf[i]);
        assign ovl_v[i] = r.v[i] && (r.base[i] < r.cmd_lba + 32'(r.cmd_cnt))
            && (r.cmd_lba < r.base[i] + 32'(r.len[i]));
    end

    assign segn = r.page[F_SEGN +: 8];
    assign maxpf = r.page[F_MAXPF +: 16];
    assign fixed_n = (segn == 8'h00) ? NSEG_ONE
        : (9'(segn) > 9'(NSEG)) ? NSEG_RST : segn[SW:0];
    assign room = LEN_FULL - r.len[r.seg];
    assign gap = r.cmd_lba - r.last_end;
    assign contig = (gap == 32'h0);
    // Never read into the current segment while uncommitted write data is pending
    assign vic = (r.dirty != '0 && r.rr == r.seg) ? nxt_rr(r.rr, r.nseg) : r.rr;
    assign pf_go = !r.page[B_DRA] && r.pf_on;
    assign pf_more = (r.pf_left != 16'h0) && (r.len[r.seg] != LEN_FULL)
        && (r.page[B_DISC] || (r.r_lba % 32'(CYL_SECT) != 32'h0));

    always_comb
    begin
        n = r;
        stat = '0;
        stat[ST_BUSY] = r.busy;
        stat[ST_GOOD] = r.good;
        stat[ST_CHECK] = r.check;
        stat[ST_DEFER] = r.deferred;
        stat[ST_HIT] = r.hit;
        stat[ST_PFHIT] = r.pf_hit;
        stat[ST_PFON] = r.pf_on;
        stat[ST_SK +: 4] = r.sk;
        stat[ST_ASC +: 8] = r.asc;
        stat[ST_ERRS +: 8] = r.err_cnt;
        hi = '0;
        for (int i = NSEG - 1; i >= 0; i--)
        begin
            if (hit_v[i])
            begin
                hi = SW'(i);
            end
        end
        // Zero-wait slave: read data captured in the setup cycle
        n.pready = psel && !penable;
        n.pslverr = 1'b0;
        n.prdata = '0;
        if (psel && !penable)
        begin
            case (paddr)
                ADDR_PAGE: n.prdata = r.page;
                ADDR_LBA: n.prdata = r.cmd_lba;
                ADDR_CMD:
                begin
                    n.prdata[F_OP +: 2] = r.op;
                    n.prdata[F_CNT +: 8] = r.cmd_cnt;
                end
                ADDR_STAT: n.prdata = stat;
                ADDR_SEG:
                begin
                    n.prdata[F_NSEG +: SW + 1] = r.nseg;
                    n.prdata[F_DIRTY] = (r.dirty != '0);
                end
                default: n.pslverr = 1'b1;
            endcase
        end
        wr_acc = psel && penable && r.pready && pwrite;
        if (wr_acc && paddr == ADDR_PAGE)
        begin
            n.page = pwdata;
        end
        if (wr_acc && paddr == ADDR_LBA && !r.busy)
        begin
            n.cmd_lba = pwdata;
        end
        if (wr_acc && paddr == ADDR_STAT)
        begin
            n.good = r.good && !pwdata[ST_GOOD];
            n.check = r.check && !pwdata[ST_CHECK];
            n.deferred = r.deferred && !pwdata[ST_DEFER];
        end
        // Commands are ignored while one is in progress
        if (wr_acc && paddr == ADDR_CMD && !r.busy)
        begin
            n.op = dbc_op_t'(pwdata[F_OP +: 2]);
            n.cmd_cnt = pwdata[F_CNT +: 8];
            n.good = 1'b0;
            n.check = 1'b0;
            n.hit = 1'b0;
            n.pf_hit = 1'b0;
            n.sk = SK_NONE;
            n.asc = ASC_NONE;
            unique case (dbc_op_t'(pwdata[F_OP +: 2]))
                DBC_OP_NONE: ;
                DBC_OP_READ:
                begin
                    n.st = S_RLOOK;
                    if (r.page[B_ILV])
                    begin
                        // Short forward skips still land in the look-ahead window
                        n.pf_on = contig || (r.cmd_lba > r.last_end
                            && gap <= 32'(maxpf));
                    end
                    else
                    begin
                        n.pf_on = contig;
                    end
                    if (contig && r.nseg > NSEG_ONE)
                    begin
                        n.nseg = r.nseg - 1'b1;
                    end
                    else if (!contig && r.nseg < NSEG_RST)
                    begin
                        n.nseg = r.nseg + 1'b1;
                    end
                end
                DBC_OP_WRITE: n.st = S_WDRAIN;
                DBC_OP_SYNC: n.st = S_SYNC;
            endcase
        end
        if (r.page[B_PM])
        begin
            n.nseg = fixed_n;
        end
        // Medium answers; later sets win over the software clears above
        ack = med_rsp.ack && r.med.req;
        fail = med_rsp.err || med_rsp.seek_err;
        rd_ok = 1'b0;
        rd_fail = 1'b0;
        if (ack)
        begin
            if (med_rsp.seek_err && r.retry != TRY_MAX)
            begin
                n.retry = r.retry + 1'b1;
            end
            else
            begin
                n.retry = '0;
                n.med.req = 1'b0;
                if (r.med.wr)
                begin
                    n.dirty[r.cp] = 1'b0;
                    n.cp = nxt_p(r.cp);
                    n.c_lba = r.c_lba + 32'h1;
                    if (fail)
                    begin
                        n.deferred = n.deferred || r.wgood;
                        n.check = n.check || !r.wgood;
                        n.sk = med_rsp.seek_err ? SK_HW : SK_MED;
                        n.asc = med_rsp.seek_err ? ASC_SEEK : ASC_NONE;
                    end
                end
                else
                begin
                    rd_ok = !fail;
                    rd_fail = fail;
                end
            end
        end
        // Background commit, paused while a host read or a prefetch owns the medium
        if (!r.med.req && r.dirty[r.cp] && r.st != S_RMED && r.st != S_PREF)
        begin
            n.med = '{1'b1, 1'b1, r.c_lba};
        end
        unique case (r.st)
            S_IDLE: ;
            S_WDRAIN:
            begin
                // Only one segment may hold dirty data at a time
                if (r.dirty == '0 && !r.med.req)
                begin
                    for (int i = 0; i < NSEG; i++)
                    begin
                        if (ovl_v[i])
                        begin
                            n.v[i] = 1'b0;
                        end
                    end
                    n.seg = r.rr;
                    n.rr = nxt_rr(r.rr, r.nseg);
                    n.base[r.rr] = r.cmd_lba;
                    n.len[r.rr] = '0;
                    n.v[r.rr] = !r.page[B_RCD];
                    n.pf[r.rr] = 1'b0;
                    n.wp = '0;
                    n.cp = '0;
                    n.c_lba = r.cmd_lba;
                    n.left = r.cmd_cnt;
                    n.wgood = 1'b0;
                    n.st = S_WFILL;
                end
            end
            S_WFILL:
            begin
                if (r.left == 8'h0)
                begin
                    if (r.page[B_WCE])
                    begin
                        n.good = 1'b1;
                        n.wgood = 1'b1;
                        n.st = S_IDLE;
                    end
                    else
                    begin
                        n.st = S_WWAIT;
                    end
                end
                else if (!r.dirty[r.wp])
                begin
                    n.dirty[r.wp] = 1'b1;
                    n.wp = nxt_p(r.wp);
                    n.left = r.left - 8'h1;
                    if (r.len[r.seg] == LEN_FULL)
                    begin
                        n.base[r.seg] = r.base[r.seg] + 32'h1;
                    end
                    else
                    begin
                        n.len[r.seg] = r.len[r.seg] + 1'b1;
                    end
                end
            end
            S_WWAIT, S_SYNC:
            begin
                if (r.dirty == '0 && !r.med.req)
                begin
                    n.good = !n.check;
                    n.st = S_IDLE;
                end
            end
            S_RLOOK:
            begin
                if (hit_v != '0)
                begin
                    n.hit = 1'b1;
                    n.pf_hit = r.pf[hi];
                    n.good = 1'b1;
                    n.last_end = r.cmd_lba + 32'(r.cmd_cnt);
                    n.st = S_IDLE;
                end
                else if (!(r.dirty != '0 && vic == r.seg))
                begin
                    n.seg = vic;
                    n.rr = nxt_rr(vic, r.nseg);
                    n.base[vic] = r.cmd_lba;
                    n.len[vic] = '0;
                    n.v[vic] = 1'b1;
                    n.pf[vic] = 1'b0;
                    n.r_lba = r.cmd_lba;
                    n.left = (r.cmd_cnt > CNT_FULL) ? CNT_FULL : r.cmd_cnt;
                    n.st = S_RMED;
                end
            end
            S_RMED:
            begin
                if (rd_fail)
                begin
                    n.check = 1'b1;
                    n.v[r.seg] = 1'b0;
                    n.sk = med_rsp.seek_err ? SK_HW : SK_MED;
                    n.asc = med_rsp.seek_err ? ASC_POS : ASC_NONE;
                    // Retries on one block count as a single error
                    if (!med_rsp.seek_err && (!r.err_seen || r.err_lba != r.r_lba))
                    begin
                        n.err_cnt = r.err_cnt + 8'h1;
                        n.err_lba = r.r_lba;
                        n.err_seen = 1'b1;
                    end
                    n.st = S_IDLE;
                end
                else if (rd_ok)
                begin
                    n.len[r.seg] = r.len[r.seg] + 1'b1;
                    n.r_lba = r.r_lba + 32'h1;
                    n.left = r.left - 8'h1;
                end
                else if (!r.med.req && r.left != 8'h0)
                begin
                    n.med = '{1'b1, 1'b0, r.r_lba};
                end
                else if (!r.med.req)
                begin
                    n.good = 1'b1;
                    n.last_end = r.r_lba;
                    if (pf_go && room != '0)
                    begin
                        n.pf_left = (maxpf < 16'(room)) ? maxpf : 16'(room);
                        n.pf[r.seg] = 1'b1;
                        n.st = S_PREF;
                    end
                    else
                    begin
                        n.st = S_IDLE;
                    end
                end
            end
            S_PREF:
            begin
                // Prefetch errors are dropped silently; the block is read again on demand
                if (rd_fail)
                begin
                    n.st = S_IDLE;
                end
                else if (rd_ok)
                begin
                    n.len[r.seg] = r.len[r.seg] + 1'b1;
                    n.r_lba = r.r_lba + 32'h1;
                    n.pf_left = r.pf_left - 16'h1;
                end
                else if (!r.med.req && pf_more)
                begin
                    n.med = '{1'b1, 1'b0, r.r_lba};
                end
                else if (!r.med.req)
                begin
                    n.st = S_IDLE;
                end
            end
        endcase
        n.busy = (n.st != S_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.page <= PAGE_RST;
            r.nseg <= NSEG_RST;
        end
        else
        begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign med_req = r.med;

    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_fill_blocked;
        r.st == S_WFILL && r.left != 8'h0 && r.dirty[r.wp];
    endsequence
    sequence s_fill_step;
        r.st == S_WFILL && r.left != 8'h0 && !r.dirty[r.wp];
    endsequence
    sequence s_seek_fail;
        med_rsp.ack && r.med.req && !r.med.wr && med_rsp.seek_err
            && r.retry == TRY_MAX && r.st == S_RMED;
    endsequence

    property p_apb;
        s_setup |=> pready;
    endproperty
    a_apb: assert property (p_apb) else $error("pready missing in access phase");

    property p_wrap;
        s_fill_blocked |=> r.left == $past(r.left);
    endproperty
    a_wrap: assert property (p_wrap) else $error("dirty sector overwritten");

    property p_dirty;
        s_fill_step |=> r.dirty[$past(r.wp)] && r.left == $past(r.left) - 8'h1;
    endproperty
    a_dirty: assert property (p_dirty) else $error("dirty flag not set");

    property p_wce;
        r.st == S_WFILL && r.left == 8'h0 && r.page[B_WCE] |=> r.good && !r.busy;
    endproperty
    a_wce: assert property (p_wce) else $error("early good missing");

    property p_sync;
        $rose(r.good) && $past(r.st) == S_SYNC |-> r.dirty == '0 && !r.med.req;
    endproperty
    a_sync: assert property (p_sync) else $error("sync done with dirty data");

    property p_defer;
        med_rsp.ack && r.med.req && r.med.wr && med_rsp.err && !med_rsp.seek_err
            && r.wgood |=> r.deferred && r.sk == SK_MED;
    endproperty
    a_defer: assert property (p_defer) else $error("deferred error missing");

    property p_cyl;
        r.st == S_PREF && !r.page[B_DISC] && $rose(r.med.req)
            |-> r.med.lba % 32'(CYL_SECT) != 32'h0;
    endproperty
    a_cyl: assert property (p_cyl) else $error("prefetch crossed cylinder");

    property p_dra;
        $rose(r.st == S_PREF) |-> !$past(r.page[B_DRA]);
    endproperty
    a_dra: assert property (p_dra) else $error("prefetch while disabled");

    property p_pm;
        r.page[B_PM] |=> r.nseg == $past(fixed_n);
    endproperty
    a_pm: assert property (p_pm) else $error("segment count not fixed");

    property p_retry;
        med_rsp.ack && r.med.req && med_rsp.seek_err && r.retry != TRY_MAX
            |=> r.med.req && r.retry == $past(r.retry) + 1'b1;
    endproperty
    a_retry: assert property (p_retry) else $error("seek not retried");

    property p_seek;
        s_seek_fail |=> r.check && r.sk == SK_HW && r.asc == ASC_POS && !r.busy;
    endproperty
    a_seek: assert property (p_seek) else $error("seek failure not reported");

    property p_hit;
        r.st == S_RLOOK && hit_v != '0 |=> r.hit && r.good && r.st == S_IDLE;
    endproperty
    a_hit: assert property (p_hit) else $error("buffer hit not served");
endmodule : dbc_cache

/* File: include/dbc_pkg.sv */
package dbc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_PAGE = 8'h00;
    localparam logic [7:0] ADDR_LBA = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_SEG = 8'h10;
    // Caching page register fields
    localparam int B_RCD = 0;
    localparam int B_WCE = 1;
    localparam int B_DISC = 4;
    localparam int B_DRA = 5;
    localparam int B_PM = 6;
    localparam int B_ILV = 7;
    localparam int F_SEGN = 8;
    localparam int F_MAXPF = 16;
    localparam logic [31:0] PAGE_RST = 32'h0010_1000;
    // Command register fields
    localparam int F_OP = 0;
    localparam int F_CNT = 8;
    // Status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_GOOD = 1;
    localparam int ST_CHECK = 2;
    localparam int ST_DEFER = 3;
    localparam int ST_HIT = 4;
    localparam int ST_PFHIT = 5;
    localparam int ST_PFON = 6;
    localparam int ST_SK = 8;
    localparam int ST_ASC = 16;
    localparam int ST_ERRS = 24;
    // Segment register fields
    localparam int F_NSEG = 0;
    localparam int F_DIRTY = 16;
    // Sense keys and error codes
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_MED = 4'h3;
    localparam logic [3:0] SK_HW = 4'h4;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_POS = 8'h15;
    localparam logic [7:0] ASC_SEEK = 8'h02;

    typedef enum logic [1:0] {
        DBC_OP_NONE = 2'h0,
        DBC_OP_READ = 2'h1,
        DBC_OP_WRITE = 2'h2,
        DBC_OP_SYNC = 2'h3
    } dbc_op_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic [31:0] lba;
    } dbc_med_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic seek_err;
    } dbc_med_rsp_t;
endpackage : dbc_pkg

/* File: tb/dbc_med_model.sv */
`timescale 1ns/100ps
module dbc_med_model
    import dbc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Medium channel
    input wire dbc_med_req_t med_req,
    output dbc_med_rsp_t med_rsp,
    // Fault control
    input wire logic [3:0] dly,
    input wire logic [31:0] bad_lba,
    input wire logic bad_seek
);
    logic [3:0] cnt;
    logic hit;
    assign hit = med_req.lba === bad_lba;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 4'h0;
            med_rsp <= '0;
        end
        else if (med_req.req && !med_rsp.ack && cnt >= dly)
        begin
            cnt <= 4'h0;
            med_rsp <= {1'b1, hit && !bad_seek, hit && bad_seek};
        end
        else
        begin
            // Error lines toggle outside ack, so stale values never look valid
            cnt <= med_req.req && !med_rsp.ack ? cnt + 4'h1 : 4'h0;
            med_rsp <= {1'b0, ~med_rsp.err, ~med_rsp.seek_err};
        end
    end
endmodule : dbc_med_model

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top
    import dbc_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, bad_seek = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, bad_lba = 32'hFFFF_FFFF;
    logic [3:0] dly = 4'h1;
    dbc_med_req_t med_req;
    dbc_med_rsp_t med_rsp;
    int num_errors = 0, check_count = 0, cyc = 0;
    dbc_cache #(.CYL_SECT(8), .SEEK_TRIES(1)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .med_req(med_req),
        .med_rsp(med_rsp));
    dbc_med_model med (.pclk(pclk), .presetn(presetn), .med_req(med_req), .med_rsp(med_rsp),
        .dly(dly), .bad_lba(bad_lba), .bad_seek(bad_seek));
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    task automatic end_of_test();
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : ck
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Starts a command and polls status until busy drops, prefetch included
    task automatic cmd(input logic [31:0] lba, input logic [31:0] c);
        apb(1'b1, ADDR_LBA, lba);
        apb(1'b1, ADDR_CMD, c);
        do apb(1'b0, ADDR_STAT, 32'h0); while (r[ST_BUSY] !== 1'b0);
    endtask : cmd
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_PAGE, 32'h0);
        ck(r, PAGE_RST);
        apb(1'b0, ADDR_SEG, 32'h0);
        ck(r[6:0], 7'h40);
        apb(1'b0, 8'h14, 32'h0);
        ck(pslverr, 1'b1);
        apb(1'b1, ADDR_PAGE, 32'h0010_0842);
        apb(1'b0, ADDR_SEG, 32'h0);
        ck(r[6:0], 7'h08);
        dly <= 4'h5;
        cmd(32'h40, 32'h0000_0202);
        ck(r[ST_GOOD], 1'b1);
        apb(1'b0, ADDR_SEG, 32'h0);
        ck(r[F_DIRTY], 1'b1);
        cmd(32'h0, 32'h3);
        ck(r[ST_GOOD], 1'b1);
        apb(1'b0, ADDR_SEG, 32'h0);
        ck(r[F_DIRTY], 1'b0);
        dly <= 4'h1;
        cmd(32'h40, 32'h0000_0101);
        ck(r[ST_HIT], 1'b1);
        bad_lba <= 32'h50;
        cmd(32'h50, 32'h0000_0102);
        cmd(32'h0, 32'h3);
        ck(r[ST_DEFER], 1'b1);
        apb(1'b1, ADDR_STAT, 32'h0000_000E);
        bad_lba <= 32'h60;
        bad_seek <= 1'b1;
        cmd(32'h60, 32'h0000_0101);
        ck({r[ST_CHECK], r[23:16], r[11:8]}, 13'h1154);
        bad_lba <= 32'h70;
        bad_seek <= 1'b0;
        cmd(32'h70, 32'h0000_0101);
        ck({r[11:8], r[31:24]}, 12'h301);
        cmd(32'h70, 32'h0000_0101);
        ck(r[31:24], 8'h01);
        cmd(32'h41, 32'h0000_0102);
        cmd(32'h40, 32'h0000_0101);
        ck(r[ST_HIT], 1'b0);
        cmd(32'hA0, 32'h0000_0101);
        cmd(32'hA1, 32'h0000_0101);
        ck(r[ST_PFON], 1'b1);
        cmd(32'hA5, 32'h0000_0101);
        ck(r[6:4], 3'b011);
        cmd(32'hA8, 32'h0000_0101);
        ck(r[ST_HIT], 1'b0);
        // Policy zero: a non-contiguous read adds a segment
        apb(1'b1, ADDR_PAGE, 32'h0010_0802);
        cmd(32'hC0, 32'h0000_0101);
        apb(1'b0, ADDR_SEG, 32'h0);
        ck(r[6:0], 7'h09);
        // Interleave hint with read-ahead disabled: enabled, yet nothing fetched
        apb(1'b1, ADDR_PAGE, 32'h0010_08A2);
        cmd(32'hC3, 32'h0000_0101);
        ck(r[ST_PFON], 1'b1);
        cmd(32'hC4, 32'h0000_0101);
        ck(r[ST_HIT], 1'b0);
        // Two-block prefetch limit, allowed across the cylinder boundary
        apb(1'b1, ADDR_PAGE, 32'h0002_0812);
        cmd(32'hE6, 32'h0000_0101);
        cmd(32'hE7, 32'h0000_0101);
        cmd(32'hE9, 32'h0000_0101);
        ck(r[5:4], 2'b11);
        cmd(32'hEA, 32'h0000_0101);
        ck(r[ST_HIT], 1'b0);
        // Slow commits force the wrapping write to stall on dirty slots
        dly <= 4'hF;
        cmd(32'h80, 32'h0000_1202);
        ck(r[ST_GOOD], 1'b1);
        cmd(32'h82, 32'h0000_0101);
        ck(r[ST_HIT], 1'b1);
        cmd(32'h80, 32'h0000_0101);
        ck(r[ST_HIT], 1'b0);
        end_of_test();
    end
endmodule : tb_top
